// File: bitclear_breakpoint_branch_exec.sv
// decode and execute stage for bit-clear, breakpoint and branch-with-link/exchange
`timescale 1ns/10ps
module bitclear_breakpoint_branch_exec
  import bitclear_exec_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // instruction from fetch/decode
  input  wire logic        instr_valid_i,
  input  wire logic        instr_wide_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] pc_i,
  // conditional-block state
  input  wire logic        cond_pass_i,
  input  wire logic        in_cond_block_i,
  input  wire logic        last_in_cond_block_i,
  // register file read data
  input  wire logic [31:0] first_operand_data_i,
  input  wire logic [31:0] second_operand_data_i,
  // current flags and debug configuration
  input  wire logic        flag_c_i,
  input  wire logic        debug_halt_en_i,
  // register file read addresses (combinational)
  output logic      [3:0]  first_operand_field_o,
  output logic      [3:0]  second_operand_field_o,
  // result write
  output logic             reg_we_o,
  output logic      [3:0]  reg_waddr_o,
  output logic      [31:0] reg_wdata_o,
  // link register write
  output logic             link_register_we_o,
  output logic      [31:0] link_register_wdata_o,
  // flag write
  output logic             flags_we_o,
  output logic             flag_n_o,
  output logic             flag_z_o,
  output logic             flag_c_o,
  // branch
  output logic             branch_o,
  output logic      [31:0] branch_target_o,
  // exceptions and status
  output logic             debug_monitor_exception_o,
  output logic             debug_halt_o,
  output logic             usage_fault_a_o,
  output logic             unpredictable_o
);

  import bitclear_exec_pkg::*;

  // instruction halves: wide encodings put the first halfword in [31:16]
  wire logic [15:0] hw1_w = instr_wide_i ? instr_i[31:16] : instr_i[15:0];
  wire logic [15:0] hw2_w = instr_i[15:0];

  // 16-bit decodes
  wire logic dec_bic16_w  = !instr_wide_i && (hw1_w[15:6] == OP16_BIC_REG);
  wire logic dec_breakpoint_op_w   = !instr_wide_i && (hw1_w[15:8] == OP16_BREAKPOINT_OP);
  wire logic dec_bx_w     = !instr_wide_i && (hw1_w[15:7] == OP16_BX);
  wire logic dec_blx_w    = !instr_wide_i && (hw1_w[15:7] == OP16_BLX);

  // 32-bit decodes; branch-link only ever matches as a whole wide word
  wire logic dec_bic_imm_w = instr_wide_i && (hw1_w[15:11] == OP32_BIC_IMM_HI)
                             && (hw1_w[9:5] == OP32_BIC_IMM_OP) && !hw2_w[15];
  wire logic dec_bic32_w   = instr_wide_i && (hw1_w[15:9] == OP32_BIC_REG_HI)
                             && (hw1_w[8:5] == OP32_BIC_REG_OP);
  wire logic dec_bl_w      = instr_wide_i && (hw1_w[15:11] == OP32_BL_HI)
                             && (hw2_w[15:14] == OP32_BL_LO) && hw2_w[12];

  // selected operation
  op_sel_t op_w;
  assign op_w = !instr_valid_i ? OP_NONE :
                dec_breakpoint_op_w     ? OP_BREAKPOINT_OP :
                dec_bic_imm_w  ? OP_BIC_IMM :
                (dec_bic16_w || dec_bic32_w) ? OP_BIC_REG :
                dec_bl_w       ? OP_BL :
                dec_blx_w      ? OP_BLX :
                dec_bx_w       ? OP_BX : OP_NONE;

  // register fields
  wire logic [3:0] rd_w = dec_bic16_w ? {1'b0, hw1_w[2:0]} : hw2_w[11:8];
  wire logic [3:0] rn_w = dec_bic16_w ? {1'b0, hw1_w[2:0]} : hw1_w[3:0];
  wire logic [3:0] rm_w = dec_bic16_w ? {1'b0, hw1_w[5:3]} :
                          (dec_bx_w || dec_blx_w) ? hw1_w[6:3] : hw2_w[3:0];

  assign first_operand_field_o  = rn_w;
  assign second_operand_field_o = rm_w;

  // immediate expansion for the immediate form
  wire logic [11:0] imm12_w = {hw1_w[10], hw2_w[14:12], hw2_w[7:0]};
  logic [31:0] imm32_w;
  logic        imm_carry_w;

  imm_expand u_imm_expand (
    .imm12_i (imm12_w),
    .carry_i (flag_c_i),
    .imm32_o (imm32_w),
    .carry_o (imm_carry_w)
  );

  // shift of the second operand; short form forces LSL #0
  wire logic [1:0] sh_type_w = dec_bic16_w ? SHIFT_LSL : hw2_w[5:4];
  wire logic [4:0] sh_amt_w  = dec_bic16_w ? 5'h00 : {hw2_w[14:12], hw2_w[7:6]};
  logic [31:0] shifted_w;
  logic        sh_carry_w;

  reg_shifter u_reg_shifter (
    .value_i   (second_operand_data_i),
    .type_i    (sh_type_w),
    .amount_i  (sh_amt_w),
    .carry_i   (flag_c_i),
    .shifted_o (shifted_w),
    .carry_o   (sh_carry_w)
  );

  // bit-clear result and carry
  wire logic        is_imm_w    = (op_w == OP_BIC_IMM);
  wire logic [31:0] mask_w      = is_imm_w ? imm32_w : shifted_w;
  wire logic [31:0] bic_res_w   = first_operand_data_i & ~mask_w;
  wire logic        bic_carry_w = is_imm_w ? imm_carry_w : sh_carry_w;
  // short form sets flags only outside a conditional block
  wire logic        setflags_w  = dec_bic16_w ? !in_cond_block_i : hw1_w[4];

  // branch-link offset: I1/I2 are inverted xors of J1/J2 with S
  wire logic        s_w   = hw1_w[10];
  wire logic        i1_w  = ~(hw2_w[13] ^ s_w);
  wire logic        i2_w  = ~(hw2_w[11] ^ s_w);
  wire logic [24:0] off25_w = {s_w, i1_w, i2_w, hw1_w[9:0], hw2_w[10:0], 1'b0};
  wire logic [31:0] bl_off_w = {{7{off25_w[24]}}, off25_w};

  // unpredictable cases: bad register numbers or branch mid-block
  wire logic bad_rd_rn_w = (rd_w == REG_SP) || (rd_w == REG_PC)
                           || (rn_w == REG_SP) || (rn_w == REG_PC);
  wire logic bad_rm_w    = (rm_w == REG_SP) || (rm_w == REG_PC);
  wire logic mid_block_w = in_cond_block_i && !last_in_cond_block_i;
  wire logic unpred_w    = (is_imm_w && bad_rd_rn_w)
                           || (dec_bic32_w && instr_valid_i && (bad_rd_rn_w || bad_rm_w))
                           || ((op_w == OP_BL || op_w == OP_BLX || op_w == OP_BX)
                               && mid_block_w);

  // condition gating, except for breakpoint which ignores it
  wire logic exec_w = cond_pass_i && (op_w != OP_NONE) && (op_w != OP_BREAKPOINT_OP);

  // register branches to an even target would leave the only state
  wire logic state_change_w = !second_operand_data_i[0];
  wire logic reg_branch_w   = exec_w && (op_w == OP_BX || op_w == OP_BLX);

  // next values
  logic        nxt_reg_we;
  logic [3:0]  nxt_reg_waddr;
  logic [31:0] nxt_reg_wdata;
  logic        nxt_lr_we;
  logic [31:0] nxt_lr_wdata;
  logic        nxt_flags_we;
  logic        nxt_n;
  logic        nxt_z;
  logic        nxt_c;
  logic        nxt_branch;
  logic [31:0] nxt_target;
  logic        nxt_dbg_mon;
  logic        nxt_dbg_halt;
  logic        nxt_usage;

  // per-operation effects; pc_i reads as the next-instruction PC for wide forms, two ahead of it for short ones
  always_comb
  begin
    nxt_reg_we    = 1'b0;
    nxt_reg_waddr = rd_w;
    nxt_reg_wdata = bic_res_w;
    nxt_lr_we     = 1'b0;
    nxt_lr_wdata  = WORD_ZERO;
    nxt_flags_we  = 1'b0;
    nxt_n         = bic_res_w[RESULT_MSB];
    nxt_z         = (bic_res_w == WORD_ZERO);
    nxt_c         = bic_carry_w;
    nxt_branch    = 1'b0;
    nxt_target    = WORD_ZERO;
    nxt_dbg_mon   = 1'b0;
    nxt_dbg_halt  = 1'b0;
    nxt_usage     = 1'b0;
    case (op_w)
      OP_BIC_IMM, OP_BIC_REG:
        if (exec_w)
        begin
          nxt_reg_we   = 1'b1;
          nxt_flags_we = setflags_w;
        end
      OP_BREAKPOINT_OP:
      begin
        // immediate field never read; config picks halt or monitor
        nxt_dbg_halt = debug_halt_en_i;
        nxt_dbg_mon  = !debug_halt_en_i;
      end
      OP_BL:
        if (exec_w)
        begin
          nxt_lr_we    = 1'b1;
          nxt_lr_wdata = {pc_i[31:1], 1'b1};
          nxt_branch   = 1'b1;
          nxt_target   = 32'(pc_i + bl_off_w);
        end
      OP_BLX, OP_BX:
        if (reg_branch_w)
        begin
          // link is written before the target is checked
          nxt_lr_we    = (op_w == OP_BLX);
          nxt_lr_wdata = 32'(pc_i - PC_LINK_ADJ) | 32'h0000_0001;
          nxt_usage    = state_change_w;
          nxt_branch   = !state_change_w;
          nxt_target   = {second_operand_data_i[31:1], 1'b0};
        end
      default:
      begin
        nxt_reg_we = 1'b0;
      end
    endcase
  end

  // registered outputs
  logic        reg_we_ff;
  logic [3:0]  reg_waddr_ff;
  logic [31:0] reg_wdata_ff;
  logic        lr_we_ff;
  logic [31:0] lr_wdata_ff;
  logic        flags_we_ff;
  logic        n_ff;
  logic        z_ff;
  logic        c_ff;
  logic        branch_ff;
  logic [31:0] target_ff;
  logic        dbg_mon_ff;
  logic        dbg_halt_ff;
  logic        usage_ff;
  logic        unpred_ff;

  // strobes: cleared on reset, one cycle per accepted instruction
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      reg_we_ff   <= 1'b0;
      lr_we_ff    <= 1'b0;
      flags_we_ff <= 1'b0;
      branch_ff   <= 1'b0;
      dbg_mon_ff  <= 1'b0;
      dbg_halt_ff <= 1'b0;
      usage_ff    <= 1'b0;
      unpred_ff   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      reg_we_ff   <= nxt_reg_we;
      lr_we_ff    <= nxt_lr_we;
      flags_we_ff <= nxt_flags_we;
      branch_ff   <= nxt_branch;
      dbg_mon_ff  <= nxt_dbg_mon;
      dbg_halt_ff <= nxt_dbg_halt;
      usage_ff    <= nxt_usage;
      unpred_ff   <= unpred_w;
    end
  end

  // data: also reset so outputs are defined from the start
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      reg_waddr_ff <= 4'h0;
      reg_wdata_ff <= WORD_ZERO;
      lr_wdata_ff  <= WORD_ZERO;
      n_ff         <= 1'b0;
      z_ff         <= 1'b0;
      c_ff         <= 1'b0;
      target_ff    <= WORD_ZERO;
    end
    else if (clk_en_i)
    begin
      reg_waddr_ff <= nxt_reg_waddr;
      reg_wdata_ff <= nxt_reg_wdata;
      lr_wdata_ff  <= nxt_lr_wdata;
      n_ff         <= nxt_n;
      z_ff         <= nxt_z;
      c_ff         <= nxt_c;
      target_ff    <= nxt_target;
    end
  end

  assign reg_we_o                  = reg_we_ff;
  assign reg_waddr_o               = reg_waddr_ff;
  assign reg_wdata_o               = reg_wdata_ff;
  assign link_register_we_o        = lr_we_ff;
  assign link_register_wdata_o     = lr_wdata_ff;
  assign flags_we_o                = flags_we_ff;
  assign flag_n_o                  = n_ff;
  assign flag_z_o                  = z_ff;
  assign flag_c_o                  = c_ff;
  assign branch_o                  = branch_ff;
  assign branch_target_o           = target_ff;
  assign debug_monitor_exception_o = dbg_mon_ff;
  assign debug_halt_o              = dbg_halt_ff;
  assign usage_fault_a_o           = usage_ff;
  assign unpredictable_o           = unpred_ff;

endmodule : bitclear_breakpoint_branch_exec

// File: bitclear_exec_pkg.sv
// constants and types shared by the bit-clear / breakpoint / branch executor
package bitclear_exec_pkg;

  // register numbers with special meaning
  localparam logic [3:0] REG_SP = 4'hD;
  localparam logic [3:0] REG_PC = 4'hF;

  // 16-bit opcode patterns
  localparam logic [9:0] OP16_BIC_REG = 10'h10E;   // 0100001110 Rm Rdn
  localparam logic [7:0] OP16_BREAKPOINT_OP    = 8'hBE;     // 10111110 imm8
  localparam logic [8:0] OP16_BX      = 9'h08E;    // 010001110 Rm 000
  localparam logic [8:0] OP16_BLX     = 9'h08F;    // 010001111 Rm 000

  // 32-bit opcode patterns (first halfword fields, except OP32_BL_LO in the second halfword)
  localparam logic [4:0] OP32_BIC_IMM_HI = 5'h1E;  // 11110 at [15:11]
  localparam logic [4:0] OP32_BIC_IMM_OP = 5'h01;  // 0 0001 at [9:5] of first half
  localparam logic [6:0] OP32_BIC_REG_HI = 7'h75;  // 1110101 at [15:9]
  localparam logic [3:0] OP32_BIC_REG_OP = 4'h1;   // 0001 at [8:5]
  localparam logic [4:0] OP32_BL_HI      = 5'h1E;  // 11110 first half
  localparam logic [1:0] OP32_BL_LO      = 2'h3;   // 11 at second half [15:14]

  // shift type encodings
  localparam logic [1:0] SHIFT_LSL = 2'h0;
  localparam logic [1:0] SHIFT_LSR = 2'h1;
  localparam logic [1:0] SHIFT_ASR = 2'h2;
  localparam logic [1:0] SHIFT_ROR = 2'h3;

  // values
  localparam logic [31:0] PC_LINK_ADJ  = 32'h0000_0002;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  localparam int          RESULT_MSB   = 31;

  // operation selected by the decoder
  typedef enum logic [2:0] {
    OP_NONE,
    OP_BIC_IMM,
    OP_BIC_REG,
    OP_BREAKPOINT_OP,
    OP_BL,
    OP_BLX,
    OP_BX
  } op_sel_t;

endpackage : bitclear_exec_pkg

// File: imm_expand.sv
// modified-immediate expansion with carry-out for the 32-bit bit-clear form
`timescale 1ns/10ps
module imm_expand
  import bitclear_exec_pkg::*;
(
  // encoded immediate i:imm3:imm8 and current carry
  input  wire logic [11:0] imm12_i,
  input  wire logic        carry_i,
  // expanded value and carry-out
  output logic      [31:0] imm32_o,
  output logic             carry_o
);

  wire logic [7:0]  byte_w  = imm12_i[7:0];
  wire logic [31:0] unrot_w = {24'h00_0000, 1'b1, imm12_i[6:0]};
  wire logic [4:0]  rot_w   = imm12_i[11:7];
  wire logic [31:0] rotated_w = (unrot_w >> rot_w) | (unrot_w << (6'h20 - {1'b0, rot_w}));

  // replicated patterns keep the carry, rotated constants carry out bit 31
  always_comb
  begin
    imm32_o = rotated_w;
    carry_o = rotated_w[31];
    if (imm12_i[11:10] == 2'h0)
    begin
      carry_o = carry_i;
      case (imm12_i[9:8])
        2'h0:    imm32_o = {24'h00_0000, byte_w};
        2'h1:    imm32_o = {8'h00, byte_w, 8'h00, byte_w};
        2'h2:    imm32_o = {byte_w, 8'h00, byte_w, 8'h00};
        default: imm32_o = {byte_w, byte_w, byte_w, byte_w};
      endcase
    end
  end

endmodule : imm_expand

// File: reg_shifter.sv
// immediate-amount shifter with carry-out for the register bit-clear form
`timescale 1ns/10ps
module reg_shifter
  import bitclear_exec_pkg::*;
(
  // operand, shift type and 5-bit amount field
  input  wire logic [31:0] value_i,
  input  wire logic [1:0]  type_i,
  input  wire logic [4:0]  amount_i,
  input  wire logic        carry_i,
  // shifted value and carry-out
  output logic      [31:0] shifted_o,
  output logic             carry_o
);

  // zero amount means 32 for LSR/ASR and RRX for ROR
  wire logic        zero_amt_w = (amount_i == 5'h00);
  wire logic [32:0] lsl_w      = {1'b0, value_i} << amount_i;
  wire logic [32:0] lsr_w      = {value_i, 1'b0} >> amount_i;
  wire logic [32:0] asr_w      = 33'($signed({value_i, 1'b0}) >>> amount_i);
  wire logic [31:0] ror_w      = (value_i >> amount_i) | (value_i << (6'h20 - {1'b0, amount_i}));

  always_comb
  begin
    shifted_o = value_i;
    carry_o   = carry_i;
    case (type_i)
      SHIFT_LSL:
        if (!zero_amt_w)
        begin
          shifted_o = lsl_w[31:0];
          carry_o   = lsl_w[32];
        end
      SHIFT_LSR:
      begin
        shifted_o = zero_amt_w ? WORD_ZERO : lsr_w[32:1];
        carry_o   = zero_amt_w ? value_i[31] : lsr_w[0];
      end
      SHIFT_ASR:
      begin
        shifted_o = zero_amt_w ? {32{value_i[31]}} : asr_w[32:1];
        carry_o   = zero_amt_w ? value_i[31] : asr_w[0];
      end
      default:
      begin
        shifted_o = zero_amt_w ? {carry_i, value_i[31:1]} : ror_w;
        carry_o   = zero_amt_w ? value_i[0] : ror_w[31];
      end
    endcase
  end

endmodule : reg_shifter

// File: bitclear_exec_monitor.sv
// concurrent checks on the ports of the bit-clear / breakpoint / branch executor
`timescale 1ns/10ps
module bitclear_exec_monitor
  import bitclear_exec_pkg::*;
(
  // clock, reset and instruction side
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        clk_en_i,
  input wire logic        instr_valid_i,
  input wire logic        instr_wide_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] pc_i,
  input wire logic        cond_pass_i,
  input wire logic        in_cond_block_i,
  input wire logic        last_in_cond_block_i,
  input wire logic [31:0] first_operand_data_i,
  input wire logic [31:0] second_operand_data_i,
  input wire logic        debug_halt_en_i,
  // observed results
  input wire logic        reg_we_o,
  input wire logic [31:0] reg_wdata_o,
  input wire logic        link_register_we_o,
  input wire logic [31:0] link_register_wdata_o,
  input wire logic        flags_we_o,
  input wire logic        branch_o,
  input wire logic [31:0] branch_target_o,
  input wire logic        debug_monitor_exception_o,
  input wire logic        debug_halt_o,
  input wire logic        usage_fault_a_o,
  input wire logic        unpredictable_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // own decode of the watched opcodes, kept apart from the design's decoder
  wire logic        take    = clk_en_i && instr_valid_i && rst_n_i;
  wire logic        narrow  = take && !instr_wide_i;
  wire logic        breakpoint_op    = narrow && (instr_i[15:8] == OP16_BREAKPOINT_OP);
  wire logic        rbr     = narrow && (instr_i[15:7] == OP16_BX);
  wire logic        call    = narrow && (instr_i[15:7] == OP16_BLX);
  wire logic        bic16   = narrow && (instr_i[15:6] == OP16_BIC_REG);
  wire logic        bl      = take && instr_wide_i && (instr_i[31:27] == OP32_BL_HI)
                              && (instr_i[15:14] == OP32_BL_LO) && instr_i[12];
  wire logic        mid     = in_cond_block_i && !last_in_cond_block_i;
  wire logic [31:0] bic_res = first_operand_data_i & ~second_operand_data_i;

  // a taken call, then its branch and link strobes one cycle later
  sequence s_bl_take;
    bl && cond_pass_i;
  endsequence
  sequence s_bl_done;
    branch_o && link_register_we_o;
  endsequence

  AST_BREAKPOINT_OP_MON: assert property (breakpoint_op && !debug_halt_en_i |=> debug_monitor_exception_o && !debug_halt_o)
    else $error("breakpoint did not raise the monitor exception");
  AST_BREAKPOINT_OP_HALT: assert property (breakpoint_op && debug_halt_en_i |=> debug_halt_o && !reg_we_o && !branch_o)
    else $error("breakpoint did not halt or wrote state");
  AST_BX_TARGET: assert property (rbr && cond_pass_i && second_operand_data_i[0] |=> branch_o
    && !link_register_we_o && branch_target_o == ($past(second_operand_data_i) & 32'hFFFF_FFFE))
    else $error("register branch target or link write wrong");
  AST_BX_FAULT: assert property (rbr && cond_pass_i && !second_operand_data_i[0] |=> usage_fault_a_o && !branch_o)
    else $error("state change target did not fault");
  AST_BLX_LINK: assert property (call && cond_pass_i |=> link_register_we_o
    && link_register_wdata_o == (($past(pc_i) - PC_LINK_ADJ) | 32'h0000_0001))
    else $error("register call link value wrong");
  AST_BL_LINK: assert property (s_bl_take |=> s_bl_done ##0 link_register_wdata_o == ($past(pc_i) | 32'h0000_0001))
    else $error("call link value wrong");
  AST_COND_FAIL: assert property (take && !cond_pass_i && !breakpoint_op |=> !(reg_we_o || link_register_we_o
    || flags_we_o || branch_o || usage_fault_a_o))
    else $error("failed condition still changed state");
  AST_BIC16: assert property (bic16 && cond_pass_i |=> reg_we_o && reg_wdata_o == $past(bic_res)
    && flags_we_o == !$past(in_cond_block_i))
    else $error("short bit-clear result or flag write wrong");
  AST_MID_BLOCK: assert property ((rbr || call || bl) && mid |=> unpredictable_o)
    else $error("branch inside block not flagged");
endmodule : bitclear_exec_monitor

bind bitclear_breakpoint_branch_exec bitclear_exec_monitor u_mon (
  .clock_i, .rst_n_i, .clk_en_i, .instr_valid_i, .instr_wide_i, .instr_i, .pc_i, .cond_pass_i,
  .in_cond_block_i, .last_in_cond_block_i, .first_operand_data_i, .second_operand_data_i,
  .debug_halt_en_i, .reg_we_o, .reg_wdata_o, .link_register_we_o, .link_register_wdata_o,
  .flags_we_o, .branch_o, .branch_target_o, .debug_monitor_exception_o, .debug_halt_o,
  .usage_fault_a_o, .unpredictable_o
);

// File: tb_bitclear_breakpoint_branch_exec.sv
// self-checking bench for the bit-clear / breakpoint / branch executor
`timescale 1ns/10ps
module tb_bitclear_breakpoint_branch_exec;
  import bitclear_exec_pkg::*;
  // stimulus and observed ports
  logic        clock_i, rst_n_i, clk_en_i, instr_valid_i, instr_wide_i, cond_pass_i;
  logic        in_cond_block_i, last_in_cond_block_i, flag_c_i, debug_halt_en_i;
  logic [31:0] instr_i, pc_i, first_operand_data_i, second_operand_data_i;
  logic [3:0]  first_operand_field_o, second_operand_field_o, reg_waddr_o;
  logic        reg_we_o, link_register_we_o, flags_we_o, flag_n_o, flag_z_o, flag_c_o;
  logic        branch_o, debug_monitor_exception_o, debug_halt_o, usage_fault_a_o;
  logic        unpredictable_o;
  logic [31:0] reg_wdata_o, link_register_wdata_o, branch_target_o;
  int          mismatches;
  int          compares;

  bitclear_breakpoint_branch_exec u_dut (
    .clock_i, .rst_n_i, .clk_en_i, .instr_valid_i, .instr_wide_i, .instr_i, .pc_i,
    .cond_pass_i, .in_cond_block_i, .last_in_cond_block_i, .first_operand_data_i,
    .second_operand_data_i, .flag_c_i, .debug_halt_en_i, .first_operand_field_o,
    .second_operand_field_o, .reg_we_o, .reg_waddr_o, .reg_wdata_o, .link_register_we_o,
    .link_register_wdata_o, .flags_we_o, .flag_n_o, .flag_z_o, .flag_c_o, .branch_o,
    .branch_target_o, .debug_monitor_exception_o, .debug_halt_o, .usage_fault_a_o,
    .unpredictable_o
  );

  // 250 MHz core clock
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // strobe order: reg, link, flags, branch, monitor, halt, fault
  task automatic strobes(input logic [6:0] e);
    check("strobes", {25'h0, reg_we_o, link_register_we_o, flags_we_o, branch_o,
          debug_monitor_exception_o, debug_halt_o, usage_fault_a_o}, {25'h0, e});
  endtask : strobes

  // one instruction for one enabled edge; outputs are settled on return
  // valid stays up: the next call replaces the word before the next edge
  task automatic issue(input logic wide, input logic [31:0] word, input logic cp, input logic blk);
    instr_wide_i = wide;
    instr_i = word;
    cond_pass_i = cp;
    in_cond_block_i = blk;
    instr_valid_i = 1'b1;
    @(posedge clock_i);
    #1;
  endtask : issue

  function automatic logic [31:0] bic_imm(logic [3:0] rn, logic [3:0] rd, logic [11:0] k);
    return {5'h1E, k[11], 5'h01, 1'b1, rn, 1'b0, k[10:8], rd, k[7:0]};
  endfunction : bic_imm

  function automatic logic [31:0] bic_reg(logic [3:0] rn, logic [3:0] rd, logic [3:0] rm,
                                          logic [1:0] ty, logic [4:0] amt);
    return {OP32_BIC_REG_HI, OP32_BIC_REG_OP, 1'b1, rn, 1'b0, amt[4:2], rd, amt[1:0], ty, rm};
  endfunction : bic_reg

  // bit-clear with condition passing; n and z follow from the result
  task automatic run_bic(input logic wide, input logic [31:0] word, input logic blk,
                         input logic [31:0] a, input logic [31:0] b, input logic c,
                         input logic [31:0] res, input logic [3:0] dst, input logic cout,
                         input logic fl, input logic unp);
    first_operand_data_i = a;
    second_operand_data_i = b;
    flag_c_i = c;
    issue(wide, word, 1'b1, blk);
    strobes({1'b1, 1'b0, fl, 4'h0});
    check("result", reg_wdata_o, res);
    check("dest", {28'h0, reg_waddr_o}, {28'h0, dst});
    check("unpredictable", {31'h0, unpredictable_o}, {31'h0, unp});
    if (fl)
      check("nzc", {29'h0, flag_n_o, flag_z_o, flag_c_o}, {29'h0, res[31], res == 32'h0, cout});
  endtask : run_bic

  task automatic t_bit_clear;
    run_bic(1, bic_imm(4'h1, 4'h2, 12'h400), 0, 32'hFFFF_FFFF, 0, 0, 32'h7FFF_FFFF, 4'h2, 1, 1, 0);
    run_bic(1, bic_imm(4'h3, 4'h4, 12'h0AB), 0, 32'h0000_00AB, 0, 1, 32'h0, 4'h4, 1, 1, 0);
    run_bic(1, bic_imm(4'h1, 4'hD, 12'h0FF), 0, 32'h1234_5678, 0, 0, 32'h1234_5600, 4'hD, 0, 1, 1);
    run_bic(1, bic_reg(4'h1, 4'h2, 4'h3, SHIFT_LSL, 5'h04), 0, 32'hFF, 32'hF000_000F, 0, 32'h0F, 4'h2, 1, 1, 0);
    run_bic(1, bic_reg(4'h1, 4'h2, 4'h3, SHIFT_LSR, 5'h04), 0, 32'hFF, 32'hF8, 0, 32'hF0, 4'h2, 1, 1, 0);
    run_bic(1, bic_reg(4'h1, 4'h2, 4'h3, SHIFT_ASR, 5'h01), 0, 32'hFFFF_FFFF, 32'h8000_0001, 0, 32'h3FFF_FFFF, 4'h2, 1, 1, 0);
    run_bic(1, bic_reg(4'h1, 4'h2, 4'hF, SHIFT_ROR, 5'h08), 0, 32'hFF00_0000, 32'hFF, 0, 32'h0, 4'h2, 1, 1, 1);
    run_bic(0, {16'h0, OP16_BIC_REG, 6'h2B}, 0, 32'hFFFF_0000, 32'h00FF_00FF, 1, 32'hFF00_0000, 4'h3, 1, 1, 0);
    run_bic(0, {16'h0, OP16_BIC_REG, 6'h2B}, 1, 32'hFFFF_0000, 32'h00FF_00FF, 1, 32'hFF00_0000, 4'h3, 1, 0, 0);
    check("fields", {24'h0, first_operand_field_o, second_operand_field_o}, 32'h35);
    issue(1'b0, {16'h0, OP16_BIC_REG, 6'h2B}, 1'b0, 1'b0);
    strobes(7'h00);
  endtask : t_bit_clear

  // breakpoint inside a block with a failing condition and varied immediate
  task automatic t_breakpoint;
    for (int h = 0; h < 2; h++)
    begin
      debug_halt_en_i = h[0];
      issue(1'b0, {16'h0, OP16_BREAKPOINT_OP, 8'hA5 ^ {8{h[0]}}}, 1'b0, 1'b1);
      strobes({4'h0, !h[0], h[0], 1'b0});
    end
  endtask : t_breakpoint

  task automatic run_br(input logic wide, input logic [31:0] word, input logic [31:0] pc,
                        input logic [31:0] data, input logic [6:0] st,
                        input logic [31:0] tgt, input logic [31:0] lnk);
    pc_i = pc;
    second_operand_data_i = data;
    issue(wide, word, 1'b1, 1'b0);
    strobes(st);
    if (st[3])
      check("target", branch_target_o, tgt);
    if (st[5])
      check("link", link_register_wdata_o, lnk);
  endtask : run_br

  task automatic t_branches;
    run_br(1, 32'hF400_D000, 32'h0100_0004, 0, 7'h28, 32'h0000_0004, 32'h0100_0005);
    run_br(1, 32'hF3FF_D7FF, 32'h0100_0004, 0, 7'h28, 32'h0200_0002, 32'h0100_0005);
    run_br(0, 32'hF3FF_D7FF, 32'h0100_0004, 0, 7'h00, 0, 0);
    run_br(0, {16'h0, OP16_BX, 7'h18}, 32'h0, 32'h1001, 7'h08, 32'h1000, 0);
    check("rm field", {28'h0, second_operand_field_o}, 32'h3);
    run_br(0, {16'h0, OP16_BX, 7'h18}, 32'h0, 32'h2000, 7'h01, 0, 0);
    run_br(0, {16'h0, OP16_BLX, 7'h20}, 32'h106, 32'h3003, 7'h28, 32'h3002, 32'h105);
    run_br(0, {16'h0, OP16_BLX, 7'h20}, 32'h106, 32'h3002, 7'h21, 0, 32'h105);
    issue(1'b1, 32'hF400_D000, 1'b1, 1'b1);
    check("mid block", {31'h0, unpredictable_o}, 32'h1);
    // the last slot of a block is a legal place for a branch
    last_in_cond_block_i = 1'b1;
    issue(1'b1, 32'hF400_D000, 1'b1, 1'b1);
    check("last in block", {31'h0, unpredictable_o}, 32'h0);
    last_in_cond_block_i = 1'b0;
    issue(1'b1, 32'hF400_D000, 1'b0, 1'b0);
    strobes(7'h00);
    // a frozen enable must not take the instruction
    clk_en_i = 1'b0;
    issue(1'b0, {16'h0, OP16_BX, 7'h18}, 1'b1, 1'b0);
    clk_en_i = 1'b1;
    strobes(7'h00);
  endtask : t_branches

  // watchdog: the run is short, so a hang shows as a runaway cycle count
  initial
  begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    stop_test();
  end

  initial
  begin
    {rst_n_i, instr_valid_i, instr_wide_i, cond_pass_i, flag_c_i, debug_halt_en_i} = '0;
    {in_cond_block_i, last_in_cond_block_i} = '0;
    {instr_i, pc_i, first_operand_data_i, second_operand_data_i} = '0;
    clk_en_i = 1'b1;
    mismatches = 0;
    compares = 0;
    repeat (12) @(posedge clock_i);
    #1;
    strobes(7'h00);
    rst_n_i = 1'b1;
    t_bit_clear();
    t_breakpoint();
    t_branches();
    stop_test();
  end
endmodule : tb_bitclear_breakpoint_branch_exec
